// ===== src/mie_core.sv
`timescale 1ns/100ps
module mie_core
  import mie_pkg::*;
(
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  input  wire logic [PM_W-1:0]     i_pm_data,
  input  wire logic [7:0]          i_dm_rdata,
  input  wire logic [7:0]          i_tbl_ptr,
  input  wire logic                i_wake,
  input  wire logic                i_wdt_timeout,
  input  wire logic                i_int_ack,
  output logic      [PC_W-1:0]     o_pm_addr,
  output logic      [DM_AW-1:0]    o_dm_raddr,
  output mie_dmw_type              o_dm_write,
  output logic      [7:0]          o_acc,
  output logic      [TABLE_HIGH_BYTE_W-1:0]   o_table_high_byte,
  output mie_status_type           o_status,
  output logic                     o_wdt_clr,
  output logic                     o_halted
);

  mie_core_type st_r;
  mie_core_type st_nxt;

  // ---------------------------------------------------------------
  // decode of the held instruction
  // ---------------------------------------------------------------
  mie_op_type       op;
  logic [BIT_W-1:0] bsel;
  logic [7:0]       mop;
  logic [PC_W-1:0]  tgt;
  logic             exec;
  logic [7:0]       rd;
  logic [PC_W-1:0]  cur_pc;

  assign op     = mie_op_type'(st_r.ir[OP_LSB +: OP_W]);
  assign bsel   = st_r.ir[BIT_LSB +: BIT_W];
  assign mop    = st_r.ir[7:0];
  assign tgt    = st_r.ir[PC_W-1:0];
  assign exec   = (st_r.state == ST_RUN) && st_r.ir_valid;
  assign cur_pc = st_r.pc - PC_W'(1);

  // forward a write that the memory commits on this same edge
  always_comb begin
    if (mop == PCL_ADDR) begin
      rd = cur_pc[7:0];
    end else if (st_r.dmw.we && (st_r.dmw.addr == mop)) begin
      rd = st_r.dmw.data;
    end else begin
      rd = i_dm_rdata;
    end
  end

  // {ov, ac, c, sum}
  function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [4:0] lo;
    logic [8:0] s9;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    s9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    return {(a[7] == b[7]) && (s9[7] != a[7]), lo[4], s9[8], s9[7:0]};
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic [7:0]  res;
  logic [10:0] sum;
  logic        wr_acc;
  logic        wr_mem;
  logic        skip;
  logic        jump;
  logic [PC_W-1:0] jtgt;
  logic        lo_adj;
  logic        hi_adj;
  logic [8:0]  daa9;

  always_comb begin
    st_nxt  = st_r;
    res     = BYTE_CLR;
    sum     = '0;
    wr_acc  = 1'b0;
    wr_mem  = 1'b0;
    skip    = 1'b0;
    jump    = 1'b0;
    jtgt    = tgt;
    lo_adj  = (st_r.acc[3:0] > BCD_LIMIT) || st_r.st.ac;
    hi_adj  = (st_r.acc[7:4] > BCD_LIMIT) || st_r.st.c;
    daa9    = {1'b0, st_r.acc} + {1'b0, (hi_adj ? BCD_ADJ : NIB_ZERO), (lo_adj ? BCD_ADJ : NIB_ZERO)};
    st_nxt.dmw.we  = 1'b0;
    st_nxt.wdt_clr = 1'b0;
    if (i_int_ack) begin
      st_nxt.st.master_interrupt_enable = 1'b0;
    end
    case (st_r.state)
      ST_RUN: begin
        st_nxt.pc       = st_r.pc + PC_W'(1);
        st_nxt.ir       = i_pm_data;
        st_nxt.ir_valid = 1'b1;
        st_nxt.raddr    = i_pm_data[DM_AW-1:0];
        if (st_r.ir_valid) begin
          case (op)
            OP_MOV_A_M: begin res = rd;  wr_acc = 1'b1; end
            OP_MOV_M_A: begin res = st_r.acc; wr_mem = 1'b1; end
            OP_MOV_A_X: begin res = mop; wr_acc = 1'b1; end
            OP_ADD_A_M, OP_ADD_M, OP_ADD_A_X, OP_ADC_A_M, OP_ADC_M: begin
              sum = add8(st_r.acc, (op == OP_ADD_A_X) ? mop : rd,
                         ((op == OP_ADC_A_M) || (op == OP_ADC_M)) && st_r.st.c);
              res = sum[7:0];
              {st_nxt.st.ov, st_nxt.st.ac, st_nxt.st.c} = sum[10:8];
              st_nxt.st.z = (res == BYTE_CLR);
              wr_mem = (op == OP_ADD_M) || (op == OP_ADC_M);
              wr_acc = !wr_mem;
            end
            OP_AND_A_M, OP_AND_M, OP_AND_A_X: begin
              res = st_r.acc & ((op == OP_AND_A_X) ? mop : rd);
              st_nxt.st.z = (res == BYTE_CLR);
              wr_mem = (op == OP_AND_M);
              wr_acc = !wr_mem;
            end
            OP_CPL, OP_CPL_A: begin
              res = ~rd;
              st_nxt.st.z = (res == BYTE_CLR);
              wr_mem = (op == OP_CPL);
              wr_acc = (op == OP_CPL_A);
            end
            OP_DAA: begin
              res = daa9[7:0];
              st_nxt.st.c = daa9[8] || hi_adj;
              wr_mem = 1'b1;
            end
            OP_CLR_M:   begin res = BYTE_CLR; wr_mem = 1'b1; end
            OP_SET_M:   begin res = BYTE_SET; wr_mem = 1'b1; end
            OP_CLR_BIT: begin res = rd & ~(BIT_ONE << bsel); wr_mem = 1'b1; end
            OP_SET_BIT: begin res = rd | (BIT_ONE << bsel);  wr_mem = 1'b1; end
            OP_SWAP, OP_SWAP_A: begin
              res = {rd[3:0], rd[7:4]};
              wr_mem = (op == OP_SWAP);
              wr_acc = (op == OP_SWAP_A);
            end
            OP_JMP: jump = 1'b1;
            OP_CALL: begin
              jump = 1'b1;
              st_nxt.stack[st_r.sp] = st_r.pc;
              st_nxt.sp = st_r.sp + SP_W'(1);
            end
            OP_RET, OP_RET_A_X, OP_INTERRUPT_RETURN_OP: begin
              jump = 1'b1;
              jtgt = st_r.stack[st_r.sp - SP_W'(1)];
              st_nxt.sp = st_r.sp - SP_W'(1);
              if (op == OP_RET_A_X) begin
                res = mop;
                wr_acc = 1'b1;
              end
              if (op == OP_INTERRUPT_RETURN_OP) begin
                st_nxt.st.master_interrupt_enable = 1'b1;
              end
            end
            OP_SZ:      skip = (rd == BYTE_CLR);
            OP_SZ_A: begin
              res = rd;
              wr_acc = 1'b1;
              skip = (rd == BYTE_CLR);
            end
            OP_SZ_BIT:  skip = !rd[bsel];
            OP_SNZ_BIT: skip = rd[bsel];
            OP_SIZ, OP_SDZ, OP_SIZ_A, OP_SDZ_A: begin
              res = ((op == OP_SIZ) || (op == OP_SIZ_A)) ? rd + 8'h01 : rd - 8'h01;
              wr_mem = (op == OP_SIZ) || (op == OP_SDZ);
              wr_acc = !wr_mem;
              skip = (res == BYTE_CLR);
            end
            OP_TBL_PAGE, OP_TBL_LAST: begin
              st_nxt.pc = {(op == OP_TBL_LAST) ? LAST_PAGE : cur_pc[PC_W-1:8], i_tbl_ptr};
              st_nxt.pc_save = st_r.pc + PC_W'(1);
              st_nxt.tbl_dst = mop;
              st_nxt.state = ST_TABLE;
            end
            OP_CLR_WDT: begin
              st_nxt.wdt_clr = 1'b1;
              st_nxt.st.to = 1'b0;
              st_nxt.st.powerdown_flag = 1'b0;
            end
            OP_HALT: begin
              st_nxt.wdt_clr = 1'b1;
              st_nxt.st.to = 1'b0;
              st_nxt.st.powerdown_flag = 1'b1;
              st_nxt.state = ST_HALT;
            end
            default: ;
          endcase
          if (wr_acc) begin
            st_nxt.acc = res;
          end
          if (wr_mem) begin
            st_nxt.dmw = '{we: 1'b1, addr: mop, data: res};
            if (mop == PCL_ADDR) begin
              jump = 1'b1;
              jtgt = {cur_pc[PC_W-1:8], res};
            end
          end
          if (jump) begin
            st_nxt.pc = jtgt;
            st_nxt.ir_valid = 1'b0;
          end else if (skip) begin
            st_nxt.ir_valid = 1'b0;
          end
        end
      end
      ST_TABLE: begin
        st_nxt.table_high_byte  = i_pm_data[PM_W-1:8];
        st_nxt.dmw   = '{we: 1'b1, addr: st_r.tbl_dst, data: i_pm_data[7:0]};
        st_nxt.pc    = st_r.pc_save;
        st_nxt.state = ST_RUN;
      end
      ST_HALT: begin
        if (i_wake) begin
          st_nxt.state = ST_RUN;
        end
      end
      default: st_nxt.state = ST_RUN;
    endcase
    if (i_wdt_timeout) begin
      st_nxt.st.to = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_pm_addr  = st_r.pc;
  assign o_dm_raddr = st_r.raddr;
  assign o_dm_write = st_r.dmw;
  assign o_acc      = st_r.acc;
  assign o_table_high_byte     = st_r.table_high_byte;
  assign o_status   = st_r.st;
  assign o_wdt_clr  = st_r.wdt_clr;
  assign o_halted   = (st_r.state == ST_HALT);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  logic [3:0] alu_flags;
  assign alu_flags = {st_r.st.ov, st_r.st.z, st_r.st.ac, st_r.st.c};

  sequence s_bubble;
    ##1 (!st_r.ir_valid && (st_r.state == ST_RUN)) ##1 st_r.ir_valid;
  endsequence

  property p_skip_taken;
    exec && (op == OP_SZ) && (rd == BYTE_CLR) |-> s_bubble;
  endproperty
  a_skip_taken: assert property (p_skip_taken) else $error("taken skip lacks bubble");

  property p_skip_not_taken;
    exec && (op == OP_SNZ_BIT) && !rd[bsel] |=> st_r.ir_valid;
  endproperty
  a_skip_not_taken: assert property (p_skip_not_taken) else $error("untaken skip lost a cycle");

  property p_pcl_write;
    exec && (op == OP_MOV_M_A) && (mop == PCL_ADDR) |=> !st_r.ir_valid && (st_r.pc[7:0] == $past(st_r.acc));
  endproperty
  a_pcl_write: assert property (p_pcl_write) else $error("program counter low write not two cycles");

  property p_jump;
    exec && (op == OP_JMP) |-> (##1 (st_r.pc == $past(tgt)) && $stable(alu_flags)) and s_bubble;
  endproperty
  a_jump: assert property (p_jump) else $error("jump target or flags wrong");

  property p_call;
    exec && (op == OP_CALL) |=> (st_r.stack[st_r.sp - SP_W'(1)] == $past(st_r.pc)) && (st_r.pc == $past(tgt));
  endproperty
  a_call: assert property (p_call) else $error("call pushed wrong address");

  property p_table;
    exec && (op == OP_TBL_LAST) |=> (st_r.state == ST_TABLE) && (st_r.pc == {LAST_PAGE, $past(i_tbl_ptr)})
      ##1 (st_r.state == ST_RUN) && st_r.dmw.we && (st_r.dmw.addr == $past(mop, 2));
  endproperty
  a_table: assert property (p_table) else $error("table read sequence wrong");

  property p_clr_wdt;
    exec && (op == OP_CLR_WDT) && !i_wdt_timeout |=> st_r.wdt_clr && !st_r.st.to && !st_r.st.powerdown_flag;
  endproperty
  a_clr_wdt: assert property (p_clr_wdt) else $error("watchdog clear effects missing");

  property p_halt;
    exec && (op == OP_HALT) |=> o_halted && st_r.st.powerdown_flag && st_r.wdt_clr && $stable(alu_flags) && $stable(st_r.acc);
  endproperty
  a_halt: assert property (p_halt) else $error("power-down entry wrong");

  property p_add_carry;
    exec && (op == OP_ADC_A_M) |=> st_r.acc == 8'($past(st_r.acc) + $past(rd) + {7'h00, $past(st_r.st.c)});
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("add with carry result wrong");

  property p_clear_byte;
    exec && (op == OP_CLR_M) |=> st_r.dmw.we && (st_r.dmw.data == BYTE_CLR) && $stable(alu_flags);
  endproperty
  a_clear_byte: assert property (p_clear_byte) else $error("byte clear wrong");

  property p_interrupt_return_op;
    exec && (op == OP_INTERRUPT_RETURN_OP) |=> st_r.st.master_interrupt_enable && !st_r.ir_valid;
  endproperty
  a_interrupt_return_op: assert property (p_interrupt_return_op) else $error("interrupt return did not enable");

  property p_move_flags;
    exec && (op == OP_MOV_A_M) |=> $stable(alu_flags) && st_r.ir_valid;
  endproperty
  a_move_flags: assert property (p_move_flags) else $error("move changed flags or stalled");

endmodule

// ===== src/mie_pkg.sv
package mie_pkg;

  // ---------------------------------------------------------------
  // widths, stack depth and field positions of the instruction word
  // ---------------------------------------------------------------
  localparam int PC_W        = 11;
  localparam int PM_W        = 20;
  localparam int OP_W        = 6;
  localparam int DM_AW       = 8;
  localparam int BIT_W       = 3;
  localparam int STACK_DEPTH = 4;
  localparam int SP_W        = 2;
  localparam int TABLE_HIGH_BYTE_W      = PM_W - 8;
  localparam int OP_LSB      = 14;
  localparam int BIT_LSB     = 11;

  // ---------------------------------------------------------------
  // constants
  // ---------------------------------------------------------------
  localparam logic [DM_AW-1:0] PCL_ADDR  = 8'h06;
  localparam logic [PC_W-1:0]  RST_PC    = 11'h000;
  localparam logic [7:0]       BYTE_CLR  = 8'h00;
  localparam logic [7:0]       BYTE_SET  = 8'hFF;
  localparam logic [7:0]       BIT_ONE   = 8'h01;
  localparam logic [3:0]       BCD_LIMIT = 4'h9;
  localparam logic [3:0]       BCD_ADJ   = 4'h6;
  localparam logic [3:0]       NIB_ZERO  = 4'h0;
  localparam logic [2:0]       LAST_PAGE = 3'h7;

  // ---------------------------------------------------------------
  // opcodes and states
  // ---------------------------------------------------------------
  typedef enum logic [OP_W-1:0] {
    OP_NOP, OP_MOV_A_M, OP_MOV_M_A, OP_MOV_A_X,
    OP_ADD_A_M, OP_ADD_M, OP_ADD_A_X, OP_ADC_A_M, OP_ADC_M,
    OP_AND_A_M, OP_AND_M, OP_AND_A_X, OP_CPL, OP_CPL_A, OP_DAA,
    OP_CLR_M, OP_SET_M, OP_CLR_BIT, OP_SET_BIT,
    OP_JMP, OP_CALL, OP_RET, OP_RET_A_X, OP_INTERRUPT_RETURN_OP,
    OP_SZ, OP_SZ_A, OP_SZ_BIT, OP_SNZ_BIT,
    OP_SIZ, OP_SDZ, OP_SIZ_A, OP_SDZ_A,
    OP_TBL_PAGE, OP_TBL_LAST, OP_CLR_WDT, OP_HALT, OP_SWAP, OP_SWAP_A
  } mie_op_type;

  typedef enum logic [1:0] {ST_RUN, ST_TABLE, ST_HALT} mie_state_type;

  typedef struct packed {
    logic master_interrupt_enable;
    logic to;
    logic powerdown_flag;
    logic ov;
    logic z;
    logic ac;
    logic c;
  } mie_status_type;

  typedef struct packed {
    logic             we;
    logic [DM_AW-1:0] addr;
    logic [7:0]       data;
  } mie_dmw_type;

  typedef struct packed {
    mie_state_type                      state;
    logic [PC_W-1:0]                    pc;
    logic [PC_W-1:0]                    pc_save;
    logic [PM_W-1:0]                    ir;
    logic                               ir_valid;
    logic [DM_AW-1:0]                   raddr;
    logic [DM_AW-1:0]                   tbl_dst;
    logic [7:0]                         acc;
    logic [TABLE_HIGH_BYTE_W-1:0]                  table_high_byte;
    mie_status_type                     st;
    logic [STACK_DEPTH-1:0][PC_W-1:0]   stack;
    logic [SP_W-1:0]                    sp;
    mie_dmw_type                        dmw;
    logic                               wdt_clr;
  } mie_core_type;

endpackage

// ===== verification/mie_mem_model.sv
`timescale 1ns/100ps
module mie_mem_model
  import mie_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic [PC_W-1:0]  i_pm_addr,
  input  wire logic [DM_AW-1:0] i_dm_raddr,
  input  wire mie_dmw_type      i_dm_write,
  output logic      [PM_W-1:0]  o_pm_data,
  output logic      [7:0]       o_dm_rdata
);
  // ---------------------------------------------------------------
  // asynchronous rom and ram, ram written at the closing edge
  // ---------------------------------------------------------------
  logic [PM_W-1:0] pm [2**PC_W];
  logic [7:0]      dm [2**DM_AW];

  assign o_pm_data  = pm[i_pm_addr];
  assign o_dm_rdata = dm[i_dm_raddr];

  always @(posedge i_clk) begin
    if (i_dm_write.we) begin
      dm[i_dm_write.addr] <= i_dm_write.data;
    end
  end
endmodule

// ===== verification/tb.sv
`timescale 1ns/100ps
module tb
  import mie_pkg::*;
;
  typedef struct packed {
    logic [31:0]       cyc;
    mie_dmw_type       w;
    mie_status_type    st;
    logic [TABLE_HIGH_BYTE_W-1:0] th;
  } mie_exp_type;

  logic              clk, rst_n, wake, wdt_to, int_ack, wdt_clr, halted, hz;
  logic [7:0]        tbl_ptr, dm_rdata, r_acc, r_ptr, acc;
  logic [7:0]        r_dm [256];
  logic [PC_W-1:0]   pm_addr, pc;
  logic [PM_W-1:0]   pm_data;
  logic [DM_AW-1:0]  dm_raddr;
  logic [TABLE_HIGH_BYTE_W-1:0] table_high_byte, r_th;
  mie_dmw_type       dm_write;
  mie_status_type    status, r_st;
  mie_exp_type       exp_q [$];
  mie_exp_type       e;
  logic [32:0]       wq [$];
  logic [PC_W-1:0]   rs [$];
  int                errors, samples_checked, t, ticks, cyc;

  mie_core uut (.i_clk(clk), .i_rst_n(rst_n), .i_pm_data(pm_data), .i_dm_rdata(dm_rdata),
    .i_tbl_ptr(tbl_ptr), .i_wake(wake), .i_wdt_timeout(wdt_to), .i_int_ack(int_ack),
    .o_pm_addr(pm_addr), .o_dm_raddr(dm_raddr), .o_dm_write(dm_write), .o_acc(acc),
    .o_table_high_byte(table_high_byte), .o_status(status), .o_wdt_clr(wdt_clr), .o_halted(halted));
  mie_mem_model mem (.i_clk(clk), .i_pm_addr(pm_addr), .i_dm_raddr(dm_raddr),
    .i_dm_write(dm_write), .o_pm_data(pm_data), .o_dm_rdata(dm_rdata));

  always #4 clk = ~clk;

  // ---------------------------------------------------------------
  // reference helpers
  // ---------------------------------------------------------------
  task automatic check(string n, logic [63:0] x, logic [63:0] s);
    samples_checked++;
    if (x !== s) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  function automatic logic [11:0] add8(logic [7:0] a, logic [7:0] b, logic ci);
    logic [8:0] s;
    logic [4:0] h;
    s = a + b + ci;
    h = a[3:0] + b[3:0] + ci;
    return {a[7] == b[7] && s[7] != a[7], s[7:0] == 8'h00, h[4], s[8], s[7:0]};
  endfunction

  // expected write, flags and table-high after the instruction
  task automatic note(logic [7:0] a, logic [7:0] d, int c);
    r_dm[a] = d;
    exp_q.push_back('{hz ? 32'h0 : 32'(c), '{1'b1, a, d}, r_st, r_th});
  endtask

  task automatic setm(logic [7:0] a, logic [7:0] d);
    r_dm[a] = d;
    mem.dm[a] = d;
  endtask

  // places one instruction and advances the reference state and cycle
  task automatic ins(mie_op_type op, logic [2:0] b, logic [10:0] x);
    logic [7:0]  m;
    logic [7:0]  v;
    logic [11:0] r;
    logic [19:0] w;
    logic [10:0] a;
    logic        sk;
    int          cost;
    m = r_dm[x[7:0]];
    a = pc;
    sk = 1'b0;
    cost = 1;
    if (op == OP_JMP) x = pc + 11'h002;
    mem.pm[pc] = {op, b, x};
    pc++;
    case (op)
      OP_MOV_A_M, OP_SWAP_A: r_acc = (op == OP_SWAP_A) ? {m[3:0], m[7:4]} : m;
      OP_MOV_A_X: r_acc = x[7:0];
      OP_MOV_M_A: if (x[7:0] == PCL_ADDR) sk = 1'b1; else note(x[7:0], r_acc, t + 1);
      OP_ADD_A_M, OP_ADD_A_X, OP_ADD_M, OP_ADC_A_M, OP_ADC_M: begin
        r = add8(r_acc, (op == OP_ADD_A_X) ? x[7:0] : m, (op == OP_ADC_A_M || op == OP_ADC_M) && r_st.c);
        {r_st.ov, r_st.z, r_st.ac, r_st.c} = r[11:8];
        if (op == OP_ADD_M || op == OP_ADC_M) note(x[7:0], r[7:0], t + 1);
        else r_acc = r[7:0];
      end
      OP_AND_A_M, OP_AND_A_X, OP_AND_M, OP_CPL, OP_CPL_A: begin
        v = (op == OP_CPL || op == OP_CPL_A) ? ~m : r_acc & ((op == OP_AND_A_X) ? x[7:0] : m);
        r_st.z = (v == 8'h00);
        if (op == OP_AND_M || op == OP_CPL) note(x[7:0], v, t + 1);
        else r_acc = v;
      end
      OP_DAA: begin
        v = {(r_acc[7:4] > 4'h9 || r_st.c) ? 4'h6 : 4'h0, (r_acc[3:0] > 4'h9 || r_st.ac) ? 4'h6 : 4'h0};
        r = r_acc + v;
        r_st.c = r[8] | (v[7:4] != 4'h0);
        note(x[7:0], r[7:0], t + 1);
      end
      OP_CLR_M, OP_SET_M: note(x[7:0], (op == OP_SET_M) ? 8'hFF : 8'h00, t + 1);
      OP_CLR_BIT: note(x[7:0], m & ~(8'h01 << b), t + 1);
      OP_SET_BIT: note(x[7:0], m | (8'h01 << b), t + 1);
      OP_SWAP: note(x[7:0], {m[3:0], m[7:4]}, t + 1);
      OP_SZ, OP_SZ_A: begin
        sk = (m == 8'h00);
        if (op == OP_SZ_A) r_acc = m;
      end
      OP_SZ_BIT, OP_SNZ_BIT: sk = m[b] ^ (op == OP_SZ_BIT);
      OP_SIZ, OP_SDZ, OP_SIZ_A, OP_SDZ_A: begin
        v = (op == OP_SIZ || op == OP_SIZ_A) ? m + 8'h01 : m - 8'h01;
        sk = (v == 8'h00);
        if (op == OP_SIZ || op == OP_SDZ) note(x[7:0], v, t + 1);
        else r_acc = v;
      end
      OP_JMP: sk = 1'b1;
      OP_CALL, OP_RET, OP_RET_A_X, OP_INTERRUPT_RETURN_OP: begin
        cost = 2;
        if (op == OP_CALL) begin
          rs.push_back(pc);
          pc = x;
        end else begin
          pc = rs.pop_back();
        end
        if (op == OP_RET_A_X) r_acc = x[7:0];
        if (op == OP_INTERRUPT_RETURN_OP) r_st.master_interrupt_enable = 1'b1;
      end
      OP_TBL_PAGE, OP_TBL_LAST: begin
        w = mem.pm[{(op == OP_TBL_LAST) ? 3'h7 : a[10:8], r_ptr}];
        r_th = w[19:8];
        cost = 2;
        note(x[7:0], w[7:0], t + 2);
      end
      OP_CLR_WDT, OP_HALT: begin
        r_st.to = 1'b0;
        r_st.powerdown_flag = (op == OP_HALT);
        wq.push_back({op == OP_HALT, 32'(t + 1)});
        hz = (op == OP_HALT);
      end
      default: ;
    endcase
    // a word that must never run: a stray write to 0EE
    if (sk) begin
      mem.pm[pc] = {OP_MOV_M_A, 3'h0, 11'h0EE};
      pc++;
      cost = 2;
    end
    t += cost;
  endtask

  task automatic start();
    @(posedge clk);
    rst_n <= 1'b0;
    foreach (mem.pm[i]) mem.pm[i] = '0;
    foreach (r_dm[i]) setm(8'(i), 8'($urandom));
    r_acc = 8'h00;
    r_st = '0;
    r_th = '0;
    pc = '0;
    t = 1;
    hz = 1'b0;
    r_ptr = 8'h80 | 8'($urandom);
    tbl_ptr <= r_ptr;
  endtask

  task automatic release_rst();
    mem.pm[pc] = {OP_JMP, 3'h0, pc};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  // ---------------------------------------------------------------
  // result watcher
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc = 0;
    end else begin
      if (dm_write.we && dm_write.addr != PCL_ADDR) begin
        if (exp_q.size() == 0) begin
          check("write", 0, dm_write);
        end else begin
          e = exp_q.pop_front();
          check("write", {e.w, e.st, e.th}, {dm_write, status, table_high_byte});
          if (e.cyc != 0) check("cycle", e.cyc, cyc);
        end
      end
      if (wdt_clr) check("wdt", (wq.size() != 0) ? wq.pop_front() : 0, {halted, 32'(cyc)});
      cyc++;
    end
  end

  always @(posedge clk) begin
    ticks++;
    if (ticks > 6000) begin
      errors++;
      $display("mismatch timeout expected done seen running");
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    wake = 1'b0;
    wdt_to = 1'b0;
    int_ack = 1'b0;
    tbl_ptr = 8'h80;
    void'($urandom(32'h8a8a8fbb));
    for (int n = 0; n < 3; n++) begin
      start();
      mem.pm[{3'h7, r_ptr}] = 20'($urandom);
      mem.pm[{3'h0, r_ptr}] = 20'($urandom);
      setm(8'h29, 8'h00);
      setm(8'h2C, 8'hFF);
      setm(8'h2D, 8'h01);
      ins(OP_MOV_A_X, 3'h0, {3'h0, 8'($urandom)});
      ins(OP_ADD_A_M, 3'h0, 11'h020);
      ins(OP_MOV_M_A, 3'h0, 11'h030);
      ins(OP_ADC_A_M, 3'h0, 11'h021);
      ins(OP_ADC_M, 3'h0, 11'h022);
      ins(OP_ADD_A_X, 3'h0, {3'h0, 8'($urandom)});
      ins(OP_ADD_M, 3'h0, 11'h023);
      ins(OP_DAA, 3'h0, 11'h031);
      ins(OP_AND_A_M, 3'h0, 11'h024);
      ins(OP_AND_A_X, 3'h0, {3'h0, 8'($urandom)});
      ins(OP_AND_M, 3'h0, 11'h025);
      ins(OP_CPL, 3'h0, 11'h026);
      ins(OP_CPL_A, 3'h0, 11'h026);
      ins(OP_MOV_M_A, 3'h0, 11'h032);
      ins(OP_CLR_M, 3'h0, 11'h027);
      ins(OP_SET_M, 3'h0, 11'h028);
      ins(OP_CLR_BIT, 3'($urandom), 11'h02A);
      ins(OP_SET_BIT, 3'($urandom), 11'h02A);
      ins(OP_SWAP, 3'h0, 11'h02B);
      ins(OP_SWAP_A, 3'h0, 11'h02B);
      ins(OP_SZ, 3'h0, 11'h029);
      ins(OP_SZ_A, 3'h0, 11'h02E);
      ins(OP_SZ_BIT, 3'($urandom), 11'h02F);
      ins(OP_SNZ_BIT, 3'($urandom), 11'h02F);
      ins(OP_SIZ, 3'h0, 11'h02C);
      ins(OP_SDZ, 3'h0, 11'h02D);
      ins(OP_SIZ_A, 3'h0, 11'h020);
      ins(OP_SDZ_A, 3'h0, 11'h021);
      ins(OP_MOV_M_A, 3'h0, 11'h033);
      ins(OP_TBL_LAST, 3'h0, 11'h034);
      ins(OP_TBL_PAGE, 3'h0, 11'h035);
      ins(OP_MOV_A_X, 3'h0, {3'h0, 8'(pc + 11'h003)});
      ins(OP_MOV_M_A, 3'h0, {3'h0, PCL_ADDR});
      ins(OP_JMP, 3'h0, 11'h000);
      ins(OP_CALL, 3'h0, 11'h600);
      ins(OP_MOV_M_A, 3'h0, 11'h036);
      ins(OP_RET_A_X, 3'h0, {3'h0, 8'($urandom)});
      ins(OP_MOV_M_A, 3'h0, 11'h037);
      ins(OP_CALL, 3'h0, 11'h620);
      ins(OP_CALL, 3'h0, 11'h630);
      ins(OP_RET, 3'h0, 11'h000);
      ins(OP_MOV_M_A, 3'h0, 11'h038);
      ins(OP_INTERRUPT_RETURN_OP, 3'h0, 11'h000);
      ins(OP_CLR_WDT, 3'h0, 11'h000);
      ins(OP_MOV_M_A, 3'h0, 11'h039);
      release_rst();
      while (exp_q.size() != 0) @(posedge clk);
      @(posedge clk) int_ack <= 1'b1;
      @(posedge clk) int_ack <= 1'b0;
      @(posedge clk);
      check("emi", 1'b0, status.master_interrupt_enable);
      check("wdt left", 0, wq.size());
      check("acc", r_acc, acc);
      $display("instruction test %0d done", n);
    end
    start();
    ins(OP_NOP, 3'h0, 11'h000);
    ins(OP_NOP, 3'h0, 11'h000);
    ins(OP_NOP, 3'h0, 11'h000);
    r_st.to = 1'b1;
    ins(OP_MOV_M_A, 3'h0, 11'h040);
    ins(OP_CLR_WDT, 3'h0, 11'h000);
    ins(OP_MOV_M_A, 3'h0, 11'h041);
    ins(OP_HALT, 3'h0, 11'h000);
    ins(OP_MOV_M_A, 3'h0, 11'h042);
    release_rst();
    @(posedge clk) wdt_to <= 1'b1;
    @(posedge clk) wdt_to <= 1'b0;
    while (halted !== 1'b1) @(posedge clk);
    repeat (4) @(posedge clk);
    check("held", 1, exp_q.size());
    wake <= 1'b1;
    while (exp_q.size() != 0) @(posedge clk);
    wake <= 1'b0;
    @(posedge clk);
    check("halted", 1'b0, halted);
    check("acc", r_acc, acc);
    $display("power-down test done");
    conclude();
  end
endmodule
